// file: vah_pkg.sv
// constants, modes and register map of the voltage angle hold block
// Notes on behaviour
// - The blocking input is sampled at the start of each processing cycle, before activation is evaluated.
// - RMS levels of three phase currents and up to four voltage channels are taken on a 5 ms processing cycle.
// - Activation needs every voltage in use for the selected measurement mode to lie below the activation threshold.
// - With the current condition enabled at least one phase current must also exceed its threshold.
// - While the hold is active the activation voltage setting is presented as the reference amplitude.
// - Voltage angles of the cycle just before activation are latched and supplied for the whole active period.
// - A hold-active output is asserted whenever the hold is active, for use by the I/O routing matrix.
// - The three-phase-to-neutral and three-line-to-line modes use voltage channels A, B and C.
// - The two-line-to-line mode uses only channels A and B, holding the U12 and U32 references.
// - The two-line-plus-residual mode bases the held reference on calculated phase-to-neutral voltages.
// - An enable setting exists, and while it is off the hold never becomes active.
// - The hold ends when a settable definite maximum active time of 0.02 to 50.00 s expires.
// - The activation voltage threshold setting is accepted in the range 2 to 50 V.
// - With forced current-based tracking on and voltages absent, frequency is taken from the phase C current.
// - ON and OFF events are issued for enable, voltage low, current high, tracking, in use and blocked, filtered.
package vah_pkg;
	localparam int LVL_W = 16;
	localparam int ANG_W = 16;
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_VTHR = 5'h04;
	localparam logic [4:0] ADDR_ITHR = 5'h08;
	localparam logic [4:0] ADDR_MAXT = 5'h0c;
	localparam logic [4:0] ADDR_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;
	localparam int CTRL_W = 7;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_CUR_COND = 1;
	localparam int CTRL_FORCE_CT = 2;
	localparam int CTRL_EVT_ON = 3;
	localparam int CTRL_EVT_OFF = 4;
	localparam int CTRL_MODE_LSB = 5;
	localparam logic [6:0] CTRL_RST = 7'h18;
	localparam logic [15:0] VTHR_MIN = 16'h0002;
	localparam logic [15:0] VTHR_MAX = 16'h0032;
	localparam logic [15:0] VTHR_RST = 16'h0014;
	localparam logic [15:0] ITHR_RST = 16'h0100;
	localparam int MAXT_W = 13;
	localparam logic [12:0] MAXT_MIN = 13'h0002;
	localparam logic [12:0] MAXT_MAX = 13'h1388;
	localparam logic [12:0] MAXT_RST = 13'h0032;
	localparam int CNT_W = 14;
	localparam int EVT_N = 6;
	localparam int EV_ENABLE = 0;
	localparam int EV_VLOW = 1;
	localparam int EV_CUR_HIGH = 2;
	localparam int EV_CT_TRACK = 3;
	localparam int EV_IN_USE = 4;
	localparam int EV_BLOCKED = 5;
	localparam int IRQ_W = 2 * EVT_N;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYCLE_TIME_MS = 5;
	localparam int CYCLE_CLKS = CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int MAXT_UNIT_MS = 10;
	localparam logic [13:0] TICKS_PER_UNIT = 14'(MAXT_UNIT_MS / CYCLE_TIME_MS);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {THREE_PHASE_TO_NEUTRAL_MODE, THREE_LINE_TO_LINE_MODE,
		TWO_LINE_TO_LINE_MODE, TWO_LINE_PLUS_RESIDUAL_MODE} vah_mode_e;
	typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_SPENT} vah_state_e;
endpackage

// file: vah_ctl_if.sv
// carries the processing tick and the synchronised blocking level to the core
`timescale 1ns/1ps
`default_nettype none
interface vah_ctl_if;
	logic tick;
	logic blk;
	modport div (output tick);
	modport sync (output blk);
	modport core (input tick, input blk);
endinterface
`default_nettype wire

// file: vah_tick_div.sv
// divider making the one-cycle processing tick
`timescale 1ns/1ps
`default_nettype none
module vah_tick_div #(
	parameter int CYCLE_CLKS = vah_pkg::CYCLE_CLKS
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	vah_ctl_if.div    ctl
);
	typedef struct packed {
		logic [19:0] cnt;
		logic        tick;
	} vah_div_s;
	vah_div_s st;
	vah_div_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 20'(CYCLE_CLKS - 1))
		begin
			next_st.cnt = 20'h00000;
			next_st.tick = 1'b1;
		end
		else
			next_st.cnt = st.cnt + 20'h00001;
	end

	always_ff @(posedge aclk)
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;

	assign ctl.tick = st.tick;
endmodule // vah_tick_div
`default_nettype wire

// file: vah_sync3.sv
// three-stage synchroniser for the blocking input; accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module vah_sync3 (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic raw,
	vah_ctl_if.sync   ctl
);
	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic q;
	} vah_sync_s;
	vah_sync_s st;
	vah_sync_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.f1 = raw;
		next_st.f2 = st.f1;
		next_st.f3 = st.f2;
		if (st.f2 == st.f3)
			next_st.q = st.f3;
	end

	always_ff @(posedge aclk)
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;

	assign ctl.blk = st.q;
endmodule // vah_sync3
`default_nettype wire

// file: vah_hold.sv
// voltage angle hold core with its AXI4-Lite register file
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vah_hold #(
	parameter int CYCLE_CLKS = vah_pkg::CYCLE_CLKS,
	parameter int LVL_W      = vah_pkg::LVL_W,
	parameter int ANG_W      = vah_pkg::ANG_W
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [vah_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [vah_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       blocking_in,
	input  wire logic [LVL_W-1:0]           phase_a_current_level,
	input  wire logic [LVL_W-1:0]           phase_b_current_level,
	input  wire logic [LVL_W-1:0]           phase_c_current_level,
	input  wire logic [LVL_W-1:0]           voltage_ch1_level,
	input  wire logic [LVL_W-1:0]           voltage_ch2_level,
	input  wire logic [LVL_W-1:0]           voltage_ch3_level,
	input  wire logic [LVL_W-1:0]           voltage_ch4_level,
	input  wire logic [ANG_W-1:0]           angle_ch1,
	input  wire logic [ANG_W-1:0]           angle_ch2,
	input  wire logic [ANG_W-1:0]           angle_ch3,
	output logic                            voltage_hold_active,
	output logic [LVL_W-1:0]                ref_amplitude,
	output logic [ANG_W-1:0]                ref_angle_a,
	output logic [ANG_W-1:0]                ref_angle_b,
	output logic [ANG_W-1:0]                ref_angle_c,
	output logic                            ref_calculated,
	output logic                            freq_from_ct,
	output logic [vah_pkg::IRQ_W-1:0]       event_pulse,
	output logic                            irq
);
	typedef struct packed {
		logic [vah_pkg::CTRL_W-1:0]  ctrl;
		logic [LVL_W-1:0]            vthr;
		logic [LVL_W-1:0]            ithr;
		logic [vah_pkg::MAXT_W-1:0]  maxt;
		logic [vah_pkg::IRQ_W-1:0]   irq_stat;
		logic [vah_pkg::IRQ_W-1:0]   irq_mask;
		logic                        aw_got;
		logic [vah_pkg::ADDR_W-1:0]  awaddr;
		logic                        w_got;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
		vah_pkg::vah_state_e         fsm;
		logic                        blk;
		logic [vah_pkg::CNT_W-1:0]   cnt;
		logic [vah_pkg::EVT_N-1:0]   conds;
		logic [vah_pkg::IRQ_W-1:0]   evt;
		logic [LVL_W-1:0]            amp;
		logic [ANG_W-1:0]            ang_a;
		logic [ANG_W-1:0]            ang_b;
		logic [ANG_W-1:0]            ang_c;
		logic                        calc;
		logic                        ct_track;
	} vah_core_s;

	vah_core_s st;
	vah_core_s next_st;
	vah_ctl_if ctl ();

	vah_tick_div #(.CYCLE_CLKS(CYCLE_CLKS)) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ctl     (ctl)
	);

	vah_sync3 u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (blocking_in),
		.ctl     (ctl)
	);

	vah_pkg::vah_mode_e         mode;
	logic                       enable;
	logic                       vlow;
	logic                       cur_high;
	logic                       act_cond;
	logic [vah_pkg::CNT_W-1:0]  limit;
	logic [vah_pkg::EVT_N-1:0]  new_conds;
	logic [vah_pkg::IRQ_W-1:0]  new_evt;

	assign mode = vah_pkg::vah_mode_e'(st.ctrl[vah_pkg::CTRL_MODE_LSB +: 2]);
	assign enable = st.ctrl[vah_pkg::CTRL_ENABLE];
	assign limit = {1'b0, st.maxt} * vah_pkg::TICKS_PER_UNIT;
	// levels are taken as they stand at each processing tick
	assign cur_high = (phase_a_current_level > st.ithr) || (phase_b_current_level > st.ithr)
		|| (phase_c_current_level > st.ithr);

	// the channel set that must collapse depends on the measurement mode
	always_comb
	begin
		case (mode)
			vah_pkg::TWO_LINE_TO_LINE_MODE:
				vlow = (voltage_ch1_level < st.vthr) && (voltage_ch2_level < st.vthr);
			vah_pkg::TWO_LINE_PLUS_RESIDUAL_MODE:
				vlow = (voltage_ch1_level < st.vthr) && (voltage_ch2_level < st.vthr)
					&& (voltage_ch4_level < st.vthr);
			default:
				vlow = (voltage_ch1_level < st.vthr) && (voltage_ch2_level < st.vthr)
					&& (voltage_ch3_level < st.vthr);
		endcase
	end

	assign act_cond = enable && vlow && (cur_high || !st.ctrl[vah_pkg::CTRL_CUR_COND]);

	// condition vector evaluated with this cycle's sampled block
	assign new_conds = {ctl.blk && act_cond, next_st.fsm == vah_pkg::ST_ACTIVE,
		enable && vlow && st.ctrl[vah_pkg::CTRL_FORCE_CT], cur_high, vlow, enable};

	generate
		for (genvar i = 0; i < vah_pkg::EVT_N; i++)
		begin : g_evt
			assign new_evt[2*i] = ctl.tick && new_conds[i] && !st.conds[i] && st.ctrl[vah_pkg::CTRL_EVT_ON];
			assign new_evt[2*i+1] = ctl.tick && !new_conds[i] && st.conds[i] && st.ctrl[vah_pkg::CTRL_EVT_OFF];
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction

	always_comb
	begin
		logic [31:0] m;
		logic        clr;
		m = 32'h00000000;
		clr = 1'b0;
		next_st = st;
		if (s_axi_awvalid && !st.aw_got)
		begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_got)
		begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (st.aw_got && st.w_got && !st.bvalid)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = vah_pkg::RESP_OKAY;
			case (st.awaddr)
				vah_pkg::ADDR_CTRL:
				begin
					m = merge(32'(st.ctrl), st.wdata, st.wstrb);
					next_st.ctrl = m[vah_pkg::CTRL_W-1:0];
				end
				vah_pkg::ADDR_VTHR:
				begin
					m = merge(32'(st.vthr), st.wdata, st.wstrb);
					// out-of-range thresholds are clamped rather than refused
					if (m[LVL_W-1:0] < vah_pkg::VTHR_MIN)
						next_st.vthr = vah_pkg::VTHR_MIN;
					else if (m[LVL_W-1:0] > vah_pkg::VTHR_MAX)
						next_st.vthr = vah_pkg::VTHR_MAX;
					else
						next_st.vthr = m[LVL_W-1:0];
				end
				vah_pkg::ADDR_ITHR:
				begin
					m = merge(32'(st.ithr), st.wdata, st.wstrb);
					next_st.ithr = m[LVL_W-1:0];
				end
				vah_pkg::ADDR_MAXT:
				begin
					m = merge(32'(st.maxt), st.wdata, st.wstrb);
					if (m[vah_pkg::MAXT_W-1:0] < vah_pkg::MAXT_MIN)
						next_st.maxt = vah_pkg::MAXT_MIN;
					else if (m[vah_pkg::MAXT_W-1:0] > vah_pkg::MAXT_MAX)
						next_st.maxt = vah_pkg::MAXT_MAX;
					else
						next_st.maxt = m[vah_pkg::MAXT_W-1:0];
				end
				vah_pkg::ADDR_IRQ_MASK:
				begin
					m = merge(32'(st.irq_mask), st.wdata, st.wstrb);
					next_st.irq_mask = m[vah_pkg::IRQ_W-1:0];
				end
				vah_pkg::ADDR_STAT, vah_pkg::ADDR_IRQ_STAT:
					next_st.bresp = vah_pkg::RESP_OKAY;
				default:
					next_st.bresp = vah_pkg::RESP_SLVERR;
			endcase
		end
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && !st.rvalid)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = vah_pkg::RESP_OKAY;
			case (s_axi_araddr)
				vah_pkg::ADDR_CTRL:     next_st.rdata = 32'(st.ctrl);
				vah_pkg::ADDR_VTHR:     next_st.rdata = 32'(st.vthr);
				vah_pkg::ADDR_ITHR:     next_st.rdata = 32'(st.ithr);
				vah_pkg::ADDR_MAXT:     next_st.rdata = 32'(st.maxt);
				vah_pkg::ADDR_STAT:     next_st.rdata = 32'({st.fsm, st.calc, st.conds});
				vah_pkg::ADDR_IRQ_MASK: next_st.rdata = 32'(st.irq_mask);
				vah_pkg::ADDR_IRQ_STAT:
				begin
					next_st.rdata = 32'(st.irq_stat);
					clr = 1'b1;
				end
				default:
				begin
					next_st.rdata = 32'h00000000;
					next_st.rresp = vah_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_st.evt = new_evt;
		// a new event in the clearing read cycle survives the clear
		next_st.irq_stat = (clr ? '0 : st.irq_stat) | new_evt;
		if (ctl.tick)
		begin
			next_st.blk = ctl.blk;
			next_st.conds = new_conds;
			next_st.ct_track = new_conds[vah_pkg::EV_CT_TRACK];
			next_st.calc = mode == vah_pkg::TWO_LINE_PLUS_RESIDUAL_MODE;
			case (st.fsm)
				vah_pkg::ST_IDLE:
					if (act_cond && !ctl.blk)
					begin
						next_st.fsm = vah_pkg::ST_ACTIVE;
						next_st.cnt = '0;
						next_st.amp = st.vthr;
						// a mode switch just before activation must not leave a stale channel C angle held
						if (mode == vah_pkg::TWO_LINE_TO_LINE_MODE)
							next_st.ang_c = '0;
					end
					else
					begin
						// tracking the healthy angles keeps last cycle's set when activation comes
						next_st.ang_a = angle_ch1;
						next_st.ang_b = angle_ch2;
						next_st.ang_c = (mode == vah_pkg::TWO_LINE_TO_LINE_MODE) ? '0 : angle_ch3;
					end
				vah_pkg::ST_ACTIVE:
					if (!act_cond || ctl.blk)
						next_st.fsm = vah_pkg::ST_IDLE;
					else if (st.cnt + 14'h0001 >= limit)
						next_st.fsm = vah_pkg::ST_SPENT;
					else
						next_st.cnt = st.cnt + 14'h0001;
				vah_pkg::ST_SPENT:
					// stays spent until the fault clears, so one fault gets one timed hold
					if (!act_cond)
						next_st.fsm = vah_pkg::ST_IDLE;
				default:
					next_st.fsm = vah_pkg::ST_IDLE;
			endcase
			if (next_st.fsm != vah_pkg::ST_ACTIVE)
				next_st.amp = '0;
		end
	end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			st <= '0;
			st.ctrl <= vah_pkg::CTRL_RST;
			st.vthr <= vah_pkg::VTHR_RST;
			st.ithr <= vah_pkg::ITHR_RST;
			st.maxt <= vah_pkg::MAXT_RST;
			st.fsm <= vah_pkg::ST_IDLE;
		end
		else
			st <= next_st;

	assign s_axi_awready = !st.aw_got;
	assign s_axi_wready = !st.w_got;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign voltage_hold_active = st.fsm == vah_pkg::ST_ACTIVE;
	assign ref_amplitude = st.amp;
	assign ref_angle_a = st.ang_a;
	assign ref_angle_b = st.ang_b;
	assign ref_angle_c = st.ang_c;
	assign ref_calculated = st.calc;
	assign freq_from_ct = st.ct_track;
	assign event_pulse = st.evt;
	assign irq = |(st.irq_stat & st.irq_mask);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_go;
		ctl.tick && st.fsm == vah_pkg::ST_IDLE && act_cond && !ctl.blk;
	endsequence

	AST_BLK_SAMPLED: assert property (ctl.tick |=> st.blk == $past(ctl.blk))
		else $error("blocking level not captured at the cycle start");
	AST_GO: assert property (s_go |=> voltage_hold_active ##0 ref_amplitude == $past(st.vthr))
		else $error("hold did not start with the threshold amplitude");
	AST_NEED_VLOW: assert property ($rose(voltage_hold_active) |-> $past(vlow && enable))
		else $error("hold started without collapsed voltages");
	AST_NEED_CUR: assert property ($rose(voltage_hold_active) && st.ctrl[vah_pkg::CTRL_CUR_COND]
		|-> $past(cur_high))
		else $error("hold started without a high current");
	AST_BLOCKED: assert property (ctl.tick && ctl.blk |=> !voltage_hold_active)
		else $error("hold active while blocked");
	AST_DISABLED: assert property (ctl.tick && !enable |=> !voltage_hold_active)
		else $error("hold active while disabled");
	AST_ANGLES: assert property (voltage_hold_active && $past(voltage_hold_active)
		|-> $stable(ref_angle_a) && $stable(ref_angle_b) && $stable(ref_angle_c))
		else $error("held angles moved during the hold");
	AST_MAXT: assert property (voltage_hold_active |-> st.cnt < limit)
		else $error("hold outlived its maximum time");
	AST_VTHR: assert property (st.vthr >= vah_pkg::VTHR_MIN && st.vthr <= vah_pkg::VTHR_MAX)
		else $error("threshold out of range");
	AST_TWO_LL: assert property (voltage_hold_active && mode == vah_pkg::TWO_LINE_TO_LINE_MODE
		&& $past(mode) == vah_pkg::TWO_LINE_TO_LINE_MODE ##1 voltage_hold_active |-> ref_angle_c == '0)
		else $error("channel C angle held in two-line mode");
endmodule // vah_hold
`default_nettype wire

// file: vah_dir_stage.sv
// model of the directional stage that consumes the held voltage reference
`timescale 1ns/1ps
`default_nettype none
module vah_dir_stage (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      hold_active,
	input  wire logic [vah_pkg::ANG_W-1:0] ang_a,
	input  wire logic [vah_pkg::ANG_W-1:0] ang_b,
	output logic      [15:0]               active_clks,
	output logic                           angles_moved
);
	logic                      was_active;
	logic [vah_pkg::ANG_W-1:0] ref_a;
	logic [vah_pkg::ANG_W-1:0] ref_b;
	// a reference that moves mid-fault would swing the direction decision
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			was_active   <= 1'b0;
			active_clks  <= 16'h0000;
			angles_moved <= 1'b0;
		end
		else
		begin
			was_active <= hold_active;
			if (hold_active && !was_active)
			begin
				active_clks  <= 16'h0001;
				angles_moved <= 1'b0;
				ref_a        <= ang_a;
				ref_b        <= ang_b;
			end
			else if (hold_active)
			begin
				active_clks <= active_clks + 16'h0001;
				if (ang_a !== ref_a || ang_b !== ref_b)
					angles_moved <= 1'b1;
			end
		end
	end
endmodule // vah_dir_stage
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the voltage angle hold block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int CYC = 20;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, blocking_in;
	logic        awready, wready, bvalid, arready, rvalid, active, ref_calc, freq_ct, irq, moved;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [15:0] cur_a, cur_b, cur_c, v1, v2, v3, v4, ang1, ang2, ang3, amp, ra, rb, rc, act_clks, h1, h2;
	logic [11:0] evt;
	int          n_mismatch, num_checks, cycles, n_on;

	vah_hold #(.CYCLE_CLKS(CYC)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.blocking_in(blocking_in), .phase_a_current_level(cur_a), .phase_b_current_level(cur_b),
		.phase_c_current_level(cur_c), .voltage_ch1_level(v1), .voltage_ch2_level(v2),
		.voltage_ch3_level(v3), .voltage_ch4_level(v4), .angle_ch1(ang1), .angle_ch2(ang2),
		.angle_ch3(ang3), .voltage_hold_active(active), .ref_amplitude(amp), .ref_angle_a(ra),
		.ref_angle_b(rb), .ref_angle_c(rc), .ref_calculated(ref_calc), .freq_from_ct(freq_ct),
		.event_pulse(evt), .irq(irq));

	vah_dir_stage u_stage (.aclk(aclk), .aresetn(aresetn), .hold_active(active), .ang_a(ra),
		.ang_b(rb), .active_clks(act_clks), .angles_moved(moved));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// the ceiling leaves more than ten times the expected run length
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	// counts in-use ON pulses; each pulse stands one cycle
	always @(posedge aclk)
		if (evt[8] === 1'b1)
			n_on++;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic aw_d;
		logic w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_d && w_d))
		begin
			@(posedge aclk);
			if (awready && !aw_d)
			begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_d)
			begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd_reg(input logic [4:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_t(input int n);
		repeat (n * CYC) @(posedge aclk);
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] m, input logic cc, input logic fc, input logic en);
		return {25'h0, m, 2'b11, fc, cc, en};
	endfunction

	// a channel meant to stay up sits exactly on the threshold
	function automatic logic [15:0] lvl(input logic low);
		return low ? 16'($urandom % 32'h14) : 16'h0014;
	endfunction

	task automatic restore;
		v1 <= 16'h0014 + 16'($urandom % 32'h3e8);
		v2 <= 16'h0014 + 16'($urandom % 32'h3e8);
		v3 <= 16'h0014 + 16'($urandom % 32'h3e8);
		v4 <= 16'h0014 + 16'($urandom % 32'h3e8);
	endtask

	task automatic try_act(input logic [31:0] c, input logic [3:0] low, input logic exp);
		wr(vah_pkg::ADDR_CTRL, c);
		v1 <= lvl(low[0]);
		v2 <= lvl(low[1]);
		v3 <= lvl(low[2]);
		v4 <= lvl(low[3]);
		wait_t(3);
		chk("active", {31'h0, exp}, {31'h0, active});
		if (exp)
		begin
			chk("calc", {31'h0, c[6:5] == 2'h3}, {31'h0, ref_calc});
			chk("freq_ct", {31'h0, c[2]}, {31'h0, freq_ct});
			if (c[6:5] == 2'h2)
				chk("ang c", 32'h0, {16'h0, rc});
		end
		restore();
		wait_t(2);
		chk("idle", 32'h0, {31'h0, active});
	endtask

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, blocking_in} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = {10'h000, 32'h0, 4'hf};
		{n_mismatch, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
		void'($urandom(32'h19dc));
		{cur_a, cur_b, cur_c} = {16'($urandom % 32'h100), 16'h0000, 16'h00ff};
		{v1, v2, v3, v4} = {16'h0064, 16'h0064, 16'h0064, 16'h0064};
		{ang1, ang2, ang3} = {16'($urandom), 16'($urandom), 16'($urandom)};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(vah_pkg::ADDR_CTRL);
		chk("ctrl", 32'h18, rd);
		rd_reg(vah_pkg::ADDR_VTHR);
		chk("vthr", 32'h14, rd);
		rd_reg(vah_pkg::ADDR_ITHR);
		chk("ithr", 32'h100, rd);
		rd_reg(vah_pkg::ADDR_MAXT);
		chk("maxt", 32'h32, rd);
		rd_reg(vah_pkg::ADDR_IRQ_MASK);
		chk("mask", 32'h0, rd);
		rd_reg(5'h1c);
		chk("unmapped rd", 32'h2, {30'h0, rs});
		wr(5'h1c, 32'h5);
		chk("unmapped wr", 32'h2, {30'h0, rs});
		wr(vah_pkg::ADDR_VTHR, 32'h40);
		rd_reg(vah_pkg::ADDR_VTHR);
		chk("vthr hi", 32'h32, rd);
		wr(vah_pkg::ADDR_VTHR, 32'h1);
		rd_reg(vah_pkg::ADDR_VTHR);
		chk("vthr lo", 32'h2, rd);
		wr(vah_pkg::ADDR_VTHR, 32'h14);
		wr(vah_pkg::ADDR_MAXT, 32'h1fff);
		rd_reg(vah_pkg::ADDR_MAXT);
		chk("maxt hi", 32'h1388, rd);
		wr(vah_pkg::ADDR_MAXT, 32'h0);
		rd_reg(vah_pkg::ADDR_MAXT);
		chk("maxt lo", 32'h2, rd);
		wr(vah_pkg::ADDR_IRQ_MASK, 32'h100);
		wr(vah_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b1));
		wait_t(2);
		rd_reg(vah_pkg::ADDR_IRQ_STAT);
		h1 = ang1;
		h2 = ang2;
		v1 <= 16'h0003;
		v2 <= 16'h0000;
		v3 <= 16'h0013;
		ang1 <= h1 + 16'h4000;
		ang2 <= ~h2;
		while (!active) @(posedge aclk);
		@(posedge aclk);
		chk("amp", 32'h14, {16'h0, amp});
		chk("ang a", {16'h0, h1}, {16'h0, ra});
		chk("ang b", {16'h0, h2}, {16'h0, rb});
		chk("irq set", 32'h1, {31'h0, irq});
		rd_reg(vah_pkg::ADDR_IRQ_STAT);
		chk("in use on", 32'h1, {31'h0, rd[8]});
		@(posedge aclk);
		chk("irq clr", 32'h0, {31'h0, irq});
		while (active) @(posedge aclk);
		chk("hold len", 32'h50, {16'h0, act_clks});
		chk("moved", 32'h0, {31'h0, moved});
		wait_t(2);
		chk("spent", 32'h0, {31'h0, active});
		restore();
		wait_t(2);
		try_act(ctl(2'h0, 1'b0, 1'b0, 1'b1), 4'b0111, 1'b1);
		try_act(ctl(2'h0, 1'b0, 1'b0, 1'b1), 4'b0011, 1'b0);
		try_act(ctl(2'h1, 1'b0, 1'b0, 1'b1), 4'b0111, 1'b1);
		try_act(ctl(2'h1, 1'b0, 1'b0, 1'b1), 4'b0110, 1'b0);
		try_act(ctl(2'h2, 1'b0, 1'b0, 1'b1), 4'b0011, 1'b1);
		try_act(ctl(2'h2, 1'b0, 1'b0, 1'b1), 4'b0010, 1'b0);
		try_act(ctl(2'h3, 1'b0, 1'b0, 1'b1), 4'b1011, 1'b1);
		try_act(ctl(2'h3, 1'b0, 1'b0, 1'b1), 4'b0011, 1'b0);
		try_act(ctl(2'h0, 1'b0, 1'b0, 1'b0), 4'b0111, 1'b0);
		{cur_a, cur_b, cur_c} <= {16'h0100, 16'h0100, 16'h0100};
		try_act(ctl(2'h0, 1'b1, 1'b0, 1'b1), 4'b0111, 1'b0);
		cur_b <= 16'h0101;
		try_act(ctl(2'h0, 1'b1, 1'b0, 1'b1), 4'b0111, 1'b1);
		try_act(ctl(2'h1, 1'b0, 1'b1, 1'b1), 4'b0111, 1'b1);
		blocking_in <= 1'b1;
		try_act(ctl(2'h0, 1'b0, 1'b0, 1'b1), 4'b0111, 1'b0);
		blocking_in <= 1'b0;
		try_act(ctl(2'h0, 1'b0, 1'b0, 1'b1), 4'b0111, 1'b1);
		chk("in use events", 32'h8, n_on);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
